// ===== rtl/aspc_pkg.sv
// constants for the asynchronous serial port control block
package aspc_pkg;
  // special-function register map
  localparam logic [7:0] ASPC_SFR_PAGE = 8'h00;
  localparam logic [7:0] ASPC_ADDR_CTRL = 8'h98;
  localparam logic [7:0] ASPC_ADDR_BUF = 8'h99;
  // control register field positions
  localparam int ASPC_BIT_WIDTH = 7;
  localparam int ASPC_BIT_UNUSED = 6;
  localparam int ASPC_BIT_FILT = 5;
  localparam int ASPC_BIT_RXON = 4;
  localparam int ASPC_BIT_TX9 = 3;
  localparam int ASPC_BIT_RX9 = 2;
  localparam int ASPC_BIT_TXDONE = 1;
  localparam int ASPC_BIT_RXDONE = 0;
  localparam logic [7:0] ASPC_CTRL_RESET = 8'h40;
  localparam logic [7:0] ASPC_BUF_RESET = 8'h00;
  // frame layout
  localparam logic [3:0] ASPC_DATA_BITS = 4'h8;
  localparam logic [3:0] ASPC_FRAME8_BITS = 4'hA;
  localparam logic [3:0] ASPC_FRAME9_BITS = 4'hB;
  // tick phase that ends each two-tick bit
  localparam logic [0:0] ASPC_TICK_LAST = 1'h1;
  typedef enum logic [1:0] {ASPC_RX_IDLE, ASPC_RX_START, ASPC_RX_SHIFT} aspc_rx_e;
endpackage : aspc_pkg

// ===== rtl/aspc_serial_port.sv
// serial port control register, transmitter and receiver
`timescale 1ns/100ps
// Behaviour
// RULE1: control bit 7 selects 8-bit (0) or 9-bit (1) frames.
// RULE2: bit 6 reads as one; writes to it are ignored.
// RULE3: 8-bit mode with filter on: receive only when stop bit is high.
// RULE4: 9-bit mode with filter on: receive only when ninth bit is high.
// RULE5: bit 4 enables reception; cleared means frames are not received.
// RULE6: 9-bit mode sends tx_ninth_bit as ninth bit; unused in 8-bit mode.
// RULE7: rx_ninth_bit takes stop bit (8-bit) or ninth bit (9-bit).
// RULE8: tx_done_flag sets after eighth data bit or at start of stop bit.
// RULE9: rx_done_flag sets when stop bit is sampled, if frame accepted.
// RULE10: interrupt requested while enabled and either done flag is set.
// RULE11: software clears the done flags; hardware never clears them.
// RULE12: control register at 0x98 page 0, every bit except bit 6 individually writable.
// RULE13: 8-bit frame: start, eight data bits LSB first, stop.
// RULE14: 9-bit frame: start, eight data, ninth bit, stop; stop ignored.
// RULE15: received byte loads only while rx_done_flag is clear.
// RULE16: buffer write starts transmission; buffer read returns receive latch.
// RULE17: baud tick at twice bit rate, halved; receive timer restarts on start.
module aspc_serial_port
  import aspc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // special-function register port
  input wire logic [7:0] i_sfr_page,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_bit_wr,
  input wire logic [2:0] i_sfr_bit_sel,
  input wire logic i_sfr_bit_val,
  input wire logic i_sfr_rd,
  output logic [7:0] o_sfr_rdata,
  // interrupt
  input wire logic i_irq_en,
  output logic o_irq,
  // baud tick and serial pins
  input wire logic i_baud_tick,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic o_tx_busy
);
  import aspc_pkg::*;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  logic rx_meta_r, rx_sync_r;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end else begin
      rx_meta_r <= serial_in_pin;
      rx_sync_r <= rx_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // register access decode
  // ----------------------------------------------------------------
  logic page_hit, ctrl_sel, buf_sel;
  logic [7:0] ctrl_r, ctrl_nxt, rx_buf_r, rx_buf_nxt;
  logic tx_set, rx_accept, rx_ninth_val;
  logic [7:0] rx_shift_r, rx_shift_nxt;
  assign page_hit = (i_sfr_page == ASPC_SFR_PAGE);
  assign ctrl_sel = page_hit && (i_sfr_addr == ASPC_ADDR_CTRL);
  assign buf_sel = page_hit && (i_sfr_addr == ASPC_ADDR_BUF);

  // software writes come first, hardware sets last so a set beats a clear
  always_comb begin
    ctrl_nxt = ctrl_r;
    rx_buf_nxt = rx_buf_r;
    if (ctrl_sel && i_sfr_wr) begin
      ctrl_nxt = i_sfr_wdata; // see RULE12
    end else if (ctrl_sel && i_sfr_bit_wr) begin
      ctrl_nxt[i_sfr_bit_sel] = i_sfr_bit_val; // see RULE12
    end
    ctrl_nxt[ASPC_BIT_UNUSED] = 1'b1; // see RULE2
    if (tx_set) begin
      ctrl_nxt[ASPC_BIT_TXDONE] = 1'b1; // see RULE8
    end
    if (rx_accept) begin
      ctrl_nxt[ASPC_BIT_RXDONE] = 1'b1; // see RULE9
      ctrl_nxt[ASPC_BIT_RX9] = rx_ninth_val; // see RULE7
      rx_buf_nxt = rx_shift_r; // see RULE15
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_r <= ASPC_CTRL_RESET;
      rx_buf_r <= ASPC_BUF_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
      rx_buf_r <= rx_buf_nxt;
    end
  end

  logic mode9, filt_on, rx_on;
  assign mode9 = ctrl_r[ASPC_BIT_WIDTH]; // see RULE1
  assign filt_on = ctrl_r[ASPC_BIT_FILT];
  assign rx_on = ctrl_r[ASPC_BIT_RXON];

  // read data is registered; the buffer read returns only the receive latch
  logic [7:0] rdata_r, rdata_nxt;
  always_comb begin
    rdata_nxt = rdata_r;
    if (i_sfr_rd && ctrl_sel) begin
      rdata_nxt = ctrl_r;
    end else if (i_sfr_rd && buf_sel) begin
      rdata_nxt = rx_buf_r; // see RULE16
    end else if (i_sfr_rd) begin
      rdata_nxt = 8'h00;
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign o_sfr_rdata = rdata_r;

  // level request; flags stay until software clears them
  assign o_irq = i_irq_en && (ctrl_r[ASPC_BIT_TXDONE] || ctrl_r[ASPC_BIT_RXDONE]); // see RULE10

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  logic tx_busy_r, tx_busy_nxt, tx_ph_r, tx_ph_nxt, tx_out_r, tx_out_nxt;
  logic [3:0] tx_idx_r, tx_idx_nxt;
  logic [8:0] tx_sh_r, tx_sh_nxt;
  logic tx_bit_end;
  assign tx_bit_end = i_baud_tick && (tx_ph_r == ASPC_TICK_LAST); // see RULE17

  always_comb begin
    tx_busy_nxt = tx_busy_r;
    tx_ph_nxt = tx_ph_r;
    tx_out_nxt = tx_out_r;
    tx_idx_nxt = tx_idx_r;
    tx_sh_nxt = tx_sh_r;
    tx_set = 1'b0;
    if (buf_sel && i_sfr_wr) begin
      // a new write restarts the frame with a start bit
      tx_busy_nxt = 1'b1; // see RULE16
      tx_sh_nxt = {ctrl_r[ASPC_BIT_TX9], i_sfr_wdata}; // see RULE6
      tx_out_nxt = 1'b0;
      tx_idx_nxt = 4'h0;
      tx_ph_nxt = 1'b0;
    end else if (tx_busy_r) begin
      if (i_baud_tick) begin
        tx_ph_nxt = ~tx_ph_r;
      end
      if (tx_bit_end) begin
        tx_idx_nxt = tx_idx_r + 4'h1;
        if (tx_idx_r < ASPC_DATA_BITS || (mode9 && tx_idx_r == ASPC_DATA_BITS)) begin
          tx_out_nxt = tx_sh_r[0]; // see RULE13
          tx_sh_nxt = {1'b0, tx_sh_r[8:1]};
        end else begin
          tx_out_nxt = 1'b1;
        end
        // stop bit begins: index past data (and ninth) bits
        if (tx_idx_r == (mode9 ? ASPC_FRAME9_BITS : ASPC_FRAME8_BITS) - 4'h2) begin
          tx_set = 1'b1; // see RULE8
        end
        if (tx_idx_r == (mode9 ? ASPC_FRAME9_BITS : ASPC_FRAME8_BITS) - 4'h1) begin
          tx_busy_nxt = 1'b0; // see RULE14
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_busy_r <= 1'b0;
      tx_ph_r <= 1'b0;
      tx_out_r <= 1'b1;
      tx_idx_r <= 4'h0;
      tx_sh_r <= 9'h000;
    end else begin
      tx_busy_r <= tx_busy_nxt;
      tx_ph_r <= tx_ph_nxt;
      tx_out_r <= tx_out_nxt;
      tx_idx_r <= tx_idx_nxt;
      tx_sh_r <= tx_sh_nxt;
    end
  end
  assign serial_out_pin = tx_out_r;
  assign o_tx_busy = tx_busy_r;

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  aspc_rx_e rx_st_r, rx_st_nxt;
  logic rx_ph_r, rx_ph_nxt, rx_prev_r, rx_ninth_r, rx_ninth_nxt;
  logic [3:0] rx_idx_r, rx_idx_nxt;
  logic rx_stop_samp, rx_stop_lvl;

  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_ph_nxt = rx_ph_r;
    rx_idx_nxt = rx_idx_r;
    rx_shift_nxt = rx_shift_r;
    rx_ninth_nxt = rx_ninth_r;
    rx_stop_samp = 1'b0;
    rx_stop_lvl = rx_sync_r;
    case (rx_st_r)
      ASPC_RX_IDLE: begin
        if (rx_on && rx_prev_r && !rx_sync_r) begin // see RULE5
          rx_st_nxt = ASPC_RX_START;
          rx_ph_nxt = 1'b0; // see RULE17
        end
      end
      ASPC_RX_START: begin
        // one tick lands mid start bit; a glitch returns to idle
        if (i_baud_tick) begin
          rx_st_nxt = rx_sync_r ? ASPC_RX_IDLE : ASPC_RX_SHIFT;
          rx_idx_nxt = 4'h0;
        end
      end
      ASPC_RX_SHIFT: begin
        if (i_baud_tick) begin
          rx_ph_nxt = ~rx_ph_r;
        end
        if (i_baud_tick && rx_ph_r == ASPC_TICK_LAST) begin
          rx_idx_nxt = rx_idx_r + 4'h1;
          if (rx_idx_r < ASPC_DATA_BITS) begin
            rx_shift_nxt = {rx_sync_r, rx_shift_r[7:1]}; // see RULE13
          end else if (mode9 && rx_idx_r == ASPC_DATA_BITS) begin
            rx_ninth_nxt = rx_sync_r;
          end else begin
            rx_stop_samp = 1'b1; // see RULE9
            rx_st_nxt = ASPC_RX_IDLE;
          end
        end
      end
      default: rx_st_nxt = ASPC_RX_IDLE;
    endcase
  end

  assign rx_ninth_val = mode9 ? rx_ninth_r : rx_stop_lvl; // see RULE7
  assign rx_accept = rx_stop_samp && !ctrl_r[ASPC_BIT_RXDONE] // see RULE15
    && (!filt_on || (mode9 ? rx_ninth_r : rx_stop_lvl)); // see RULE3 see RULE4 see RULE14

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_st_r <= ASPC_RX_IDLE;
      rx_ph_r <= 1'b0;
      rx_idx_r <= 4'h0;
      rx_shift_r <= 8'h00;
      rx_ninth_r <= 1'b0;
      rx_prev_r <= 1'b1;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_ph_r <= rx_ph_nxt;
      rx_idx_r <= rx_idx_nxt;
      rx_shift_r <= rx_shift_nxt;
      rx_ninth_r <= rx_ninth_nxt;
      rx_prev_r <= rx_sync_r;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  property p_unused_one;
    ctrl_r[ASPC_BIT_UNUSED];
  endproperty
  a_unused_one: assert property (p_unused_one) else $error("unused bit not one"); // see RULE2

  // both done flags may only fall through a software write
  property p_flags_sticky;
    !(ctrl_sel && (i_sfr_wr || i_sfr_bit_wr))
      |=> (ctrl_r[ASPC_BIT_TXDONE] || !$past(ctrl_r[ASPC_BIT_TXDONE]))
      && (ctrl_r[ASPC_BIT_RXDONE] || !$past(ctrl_r[ASPC_BIT_RXDONE]));
  endproperty
  a_flags_sticky: assert property (p_flags_sticky) else $error("done flag dropped"); // see RULE11

  property p_tx_flag;
    tx_set |=> ctrl_r[ASPC_BIT_TXDONE] && serial_out_pin;
  endproperty
  a_tx_flag: assert property (p_tx_flag) else $error("tx flag or stop wrong"); // see RULE8

  property p_no_overrun;
    rx_stop_samp && ctrl_r[ASPC_BIT_RXDONE] |=> $stable(rx_buf_r);
  endproperty
  a_no_overrun: assert property (p_no_overrun) else $error("held byte overwritten"); // see RULE15

  property p_filter9;
    rx_accept && mode9 && filt_on |=> ctrl_r[ASPC_BIT_RX9];
  endproperty
  a_filter9: assert property (p_filter9) else $error("address filter failed"); // see RULE4

  property p_rx_off;
    !rx_on && rx_st_r == ASPC_RX_IDLE |=> rx_st_r == ASPC_RX_IDLE;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receiver started while off"); // see RULE5

  property p_tx_start;
    buf_sel && i_sfr_wr |=> !serial_out_pin && tx_busy_r;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("no start bit"); // see RULE16

  // follows a hardware set through the flag into the request
  property p_irq;
    (tx_set || rx_accept) ##1 i_irq_en |-> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing"); // see RULE10

  c_tx_done: cover property (tx_set);
  c_rx_accept: cover property (rx_accept && mode9);
  c_rx_drop: cover property (rx_stop_samp && !rx_accept);
endmodule : aspc_serial_port

// ===== sim/aspc_remote.sv
// far-end serial transceiver model for the serial port bench
`timescale 1ns/100ps
module aspc_remote #(
  parameter int BIT_CYC = 8
) (
  // clock
  input wire logic i_clk,
  // serial lines, idle high
  input wire logic i_line,
  output logic o_line,
  // frame format and captured frame
  input wire logic i_nine,
  output logic o_got,
  output logic [8:0] o_frame
);
  initial begin
    o_line = 1'b1;
    o_got = 1'b0;
    o_frame = 9'h000;
  end
  // -------------------------------------------------------------------
  // capture: data lsb first, then ninth bit or stop bit in slot 8
  // -------------------------------------------------------------------
  always begin
    @(negedge i_line);
    repeat (BIT_CYC / 2) @(posedge i_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYC) @(posedge i_clk);
      o_frame[i] = i_line;
    end
    // 9-bit frames still carry a stop bit to skip
    if (i_nine) repeat (BIT_CYC) @(posedge i_clk);
    o_got = 1'b1;
    @(posedge i_clk);
    o_got = 1'b0;
  end
  // b is the stop level in 8-bit frames, the ninth bit in 9-bit frames
  task automatic send(input logic [7:0] d, input logic b);
    logic [10:0] f;
    f = {1'h1, b, d, 1'h0};
    @(negedge i_clk);
    for (int i = 0; i < (i_nine ? 11 : 10); i++) begin
      o_line = f[i];
      repeat (BIT_CYC) @(negedge i_clk);
    end
    o_line = 1'b1;
  endtask : send
endmodule : aspc_remote

// ===== sim/aspc_serial_port_tb.sv
// self-checking bench for the serial port control block
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module aspc_serial_port_tb;
  import aspc_pkg::*;
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, i_irq_en = 1'b1;
  logic i_sfr_bit_wr = 1'b0, i_sfr_bit_val = 1'b0, i_baud_tick = 1'b0, nine = 1'b0;
  logic [7:0] i_sfr_page = 8'h00, i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, d, ctl;
  logic [2:0] i_sfr_bit_sel = 3'h0;
  logic [1:0] tcnt = 2'h0;
  logic [3:0] c;
  logic [3:0] cs [7] = '{4'h2, 4'h6, 4'h7, 4'hE, 4'hF, 4'hA, 4'h1};
  logic [8:0] exp_q [$];
  logic [8:0] frame, expf;
  logic [7:0] o_sfr_rdata;
  logic o_irq, serial_in_pin, serial_out_pin, o_tx_busy, got, rb, acc;
  int bad_count = 0, checks = 0;
  aspc_serial_port aspc_serial_port_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_sfr_page(i_sfr_page), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
    .i_sfr_wdata(i_sfr_wdata), .i_sfr_bit_wr(i_sfr_bit_wr), .i_sfr_bit_sel(i_sfr_bit_sel),
    .i_sfr_bit_val(i_sfr_bit_val), .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata),
    .i_irq_en(i_irq_en), .o_irq(o_irq), .i_baud_tick(i_baud_tick),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .o_tx_busy(o_tx_busy));
  aspc_remote aspc_remote_inst (.i_clk(i_clk), .i_line(serial_out_pin), .o_line(serial_in_pin),
    .i_nine(nine), .o_got(got), .o_frame(frame));
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  // tick every fourth cycle, so one bit spans eight cycles
  always @(negedge i_clk) begin
    tcnt <= tcnt + 2'h1;
    i_baud_tick <= (tcnt == 2'h3);
  end
  always @(posedge got) begin
    if (exp_q.size() == 0) begin
      bad_count++;
      $display("[FAIL] %0t unexpected frame", $time);
    end else begin
      expf = exp_q.pop_front();
      `CHK(frame, expf)
    end
  end
  task automatic stop_test;
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // an extra idle edge keeps strobes from being raised and dropped at once
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_sfr_addr = a;
    i_sfr_wdata = v;
    i_sfr_wr = 1'b1;
    @(negedge i_clk);
    i_sfr_wr = 1'b0;
    @(negedge i_clk);
  endtask : wr
  task automatic bitwr(input logic [2:0] s, input logic v);
    i_sfr_addr = ASPC_ADDR_CTRL;
    i_sfr_bit_sel = s;
    i_sfr_bit_val = v;
    i_sfr_bit_wr = 1'b1;
    @(negedge i_clk);
    i_sfr_bit_wr = 1'b0;
    @(negedge i_clk);
  endtask : bitwr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_sfr_addr = a;
    i_sfr_rd = 1'b1;
    @(negedge i_clk);
    i_sfr_rd = 1'b0;
    @(negedge i_clk);
    `CHK(o_sfr_rdata, e)
  endtask : rd
  task automatic wait_idle;
    int n;
    n = 0;
    while (o_tx_busy !== 1'b0 && n < 400) begin
      @(negedge i_clk);
      n++;
    end
    if (n == 400) begin
      bad_count++;
      $display("[FAIL] %0t transmitter hang", $time);
      stop_test();
    end
  endtask : wait_idle
  initial begin
    repeat (30000) @(posedge i_clk);
    bad_count++;
    $display("[FAIL] %0t watchdog", $time);
    stop_test();
  end
  initial begin
    void'($urandom(32'h3536));
    repeat (10) @(negedge i_clk);
    i_arst_n = 1'b1;
    @(negedge i_clk);
    rd(ASPC_ADDR_CTRL, ASPC_CTRL_RESET);
    rd(8'h9A, 8'h00);
    i_sfr_page = 8'h01;
    wr(ASPC_ADDR_CTRL, 8'h80);
    rd(ASPC_ADDR_CTRL, 8'h00);
    i_sfr_page = 8'h00;
    rd(ASPC_ADDR_CTRL, ASPC_CTRL_RESET);
    wr(ASPC_ADDR_CTRL, 8'h03);
    rd(ASPC_ADDR_CTRL, 8'h43);
    `CHK(o_irq, 1'b1)
    i_irq_en = 1'b0;
    @(negedge i_clk);
    `CHK(o_irq, 1'b0)
    i_irq_en = 1'b1;
    bitwr(3'h1, 1'b0);
    `CHK(o_irq, 1'b1)
    bitwr(3'h0, 1'b0);
    rd(ASPC_ADDR_CTRL, ASPC_CTRL_RESET);
    // transmit in both widths with both ninth-bit levels
    for (int m = 0; m < 4; m++) begin
      ctl = {m[1], 3'h4, m[0], 3'h0};
      nine = m[1];
      wr(ASPC_ADDR_CTRL, ctl);
      d = 8'($urandom);
      exp_q.push_back({m[1] ? m[0] : 1'b1, d});
      wr(ASPC_ADDR_BUF, d);
      wait_idle();
      rd(ASPC_ADDR_CTRL, ctl | 8'h02);
      rd(ASPC_ADDR_BUF, ASPC_BUF_RESET);
      bitwr(3'h1, 1'b0);
    end
    // receive table: {width, filter, receiver on, stop or ninth level}
    rb = 1'b0;
    foreach (cs[k]) begin
      c = cs[k];
      ctl = {c[3], 1'h1, c[2], c[1], 4'h0};
      nine = c[3];
      wr(ASPC_ADDR_CTRL, ctl);
      acc = c[1] & (~c[2] | c[0]);
      rb = acc & c[0];
      d = 8'($urandom);
      aspc_remote_inst.send(d, c[0]);
      repeat (8) @(negedge i_clk);
      rd(ASPC_ADDR_CTRL, ctl | {5'h0, rb, 1'b0, acc});
      `CHK(o_irq, acc)
      if (acc) rd(ASPC_ADDR_BUF, d);
      bitwr(3'h0, 1'b0);
    end
    // second frame arrives while the done flag is still set
    nine = 1'b0;
    wr(ASPC_ADDR_CTRL, 8'h50);
    aspc_remote_inst.send(8'hA5, 1'b1);
    aspc_remote_inst.send(8'h5A, 1'b0);
    repeat (8) @(negedge i_clk);
    rd(ASPC_ADDR_BUF, 8'hA5);
    rd(ASPC_ADDR_CTRL, 8'h55);
    `CHK(exp_q.size(), 0)
    stop_test();
  end
endmodule : aspc_serial_port_tb
